// ---- rtl/coax_cfg_host.sv ----
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module coax_cfg_host import coax_cfg_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  coax_cfg_if.host link
);
  typedef struct packed {
    act_kind_t kind;
    logic pin;
    logic [6:0] addr;
    logic [7:0] data;
  } act_t;

  typedef struct packed {
    host_state_t st;
    logic wait_q;
    logic [31:0] rdata;
    logic [2:0] op;
    logic nosleep;
    logic [6:0] raw_addr;
    logic [7:0] raw_data;
    logic [2:0] step;
    logic [15:0] sh;
    logic is_rd;
    logic [3:0] bitn;
    logic [2:0] div;
    logic [7:0] got;
    logic sck;
    logic ss_n;
    logic mosi;
    logic mosi_oe;
    logic tx_en;
  } host_st_t;

  host_st_t q_r;
  host_st_t q_nxt;

  function automatic act_t rd_gen();
    rd_gen = '{ACT_RD, 1'b0, REG_GENERAL, 8'h00};
  endfunction

  function automatic act_t wr_sleep(input logic [7:0] cur,
      input logic [1:0] code);
    logic [7:0] v;
    v = cur;
    v[SLEEP_LSB +: 2] = code;
    wr_sleep = '{ACT_WR, 1'b0, REG_GENERAL, v};
  endfunction

  function automatic act_t step_act(input host_st_t s);
    logic [1:0] on_code;
    act_t done;
    done = '{ACT_DONE, 1'b0, 7'h00, 8'h00};
    on_code = s.nosleep ? SLEEP_NEVER : SLEEP_AUTO;
    step_act = done;
    case (s.op)
      OP_RAW_WR:
        if (s.step == 3'h0) step_act = '{ACT_WR, 1'b0, s.raw_addr, s.raw_data};
      OP_RAW_RD:
        if (s.step == 3'h0) step_act = '{ACT_RD, 1'b0, s.raw_addr, 8'h00};
      OP_RX_MODE: begin
        case (s.step)
          3'h0: step_act = '{ACT_PIN, 1'b0, 7'h00, 8'h00};
          3'h1: step_act = rd_gen();
          3'h2: step_act = wr_sleep(s.got, on_code);
          3'h3: step_act = '{ACT_WR, 1'b0, REG_LAUNCH, LAUNCH_NOMINAL};
          default: step_act = done;
        endcase
      end
      OP_TX_MODE, OP_TX_LOOP: begin
        case (s.step)
          3'h0: step_act = rd_gen();
          3'h1: step_act = wr_sleep(s.got,
                  (s.op == OP_TX_MODE) ? SLEEP_FORCE : on_code);
          3'h2: step_act = '{ACT_PIN, 1'b1, 7'h00, 8'h00};
          default: step_act = done;
        endcase
      end
      OP_PIN_RX, OP_PIN_TX:
        if (s.step == 3'h0) begin
          step_act = '{ACT_PIN, s.op == OP_PIN_TX, 7'h00, 8'h00};
        end
      default: step_act = done;
    endcase
  endfunction

  act_t act;
  logic idle;
  logic go;

  always_comb begin
    q_nxt = q_r;
    idle = (q_r.st == S_IDLE);
    go = 1'b0;
    act = step_act(q_r);
    // Avalon: one wait cycle, then the access completes
    if ((read || write) && q_r.wait_q) begin
      q_nxt.wait_q = 1'b0;
      q_nxt.rdata = 32'h0;
      if (address == AV_ADDR) begin
        q_nxt.rdata[6:0] = q_r.raw_addr;
      end else if (address == AV_WDATA) begin
        q_nxt.rdata[7:0] = q_r.raw_data;
      end else if (address == AV_STATUS) begin
        q_nxt.rdata = {16'h0, q_r.got, 6'h0, q_r.tx_en, !idle};
      end
    end else if (!q_r.wait_q) begin
      q_nxt.wait_q = 1'b1;
      if (write && address == AV_CMD && idle) begin
        // Commands while busy are dropped; poll status first
        q_nxt.op = writedata[2:0];
        q_nxt.nosleep = writedata[CMD_NOSLEEP_BIT];
        q_nxt.step = 3'h0;
        go = 1'b1;
      end else if (write && address == AV_ADDR) begin
        q_nxt.raw_addr = writedata[6:0];
      end else if (write && address == AV_WDATA) begin
        q_nxt.raw_data = writedata[7:0];
      end
    end
    case (q_r.st)
      S_IDLE: begin
        if (go) begin
          q_nxt.st = S_STEP;
        end
      end
      S_STEP: begin
        case (act.kind)
          ACT_DONE: q_nxt.st = S_IDLE;
          ACT_PIN: begin
            q_nxt.tx_en = act.pin;
            q_nxt.step = q_r.step + 3'h1;
          end
          default: begin
            q_nxt.sh = {act.kind == ACT_RD, act.addr, act.data};
            q_nxt.is_rd = (act.kind == ACT_RD);
            q_nxt.ss_n = 1'b0;
            q_nxt.mosi = act.kind == ACT_RD;
            q_nxt.mosi_oe = 1'b1;
            q_nxt.bitn = 4'h0;
            q_nxt.div = 3'h0;
            q_nxt.st = S_FRAME;
          end
        endcase
      end
      S_FRAME: begin
        q_nxt.div = q_r.div + 3'h1;
        if (q_r.div == 3'(SCK_HALF_CYC - 1)) begin
          q_nxt.div = 3'h0;
          q_nxt.sck = !q_r.sck;
          if (!q_r.sck) begin
            if (q_r.is_rd && q_r.bitn >= 4'(HEAD_BITS)) begin
              q_nxt.got = {q_r.got[6:0], link.miso_line};
            end
          end else if (q_r.bitn == 4'(FRAME_BITS - 1)) begin
            q_nxt.ss_n = 1'b1;
            q_nxt.mosi_oe = 1'b0;
            q_nxt.div = 3'h0;
            q_nxt.st = S_GAP;
          end else begin
            // Let go only after the device has taken the eighth bit
            if (q_r.is_rd && q_r.bitn == 4'(HEAD_BITS - 1)) begin
              q_nxt.mosi_oe = 1'b0;
            end
            q_nxt.bitn = q_r.bitn + 4'h1;
            q_nxt.sh = {q_r.sh[14:0], 1'b0};
            q_nxt.mosi = q_r.sh[14];
          end
        end
      end
      S_GAP: begin
        q_nxt.div = q_r.div + 3'h1;
        if (q_r.div == 3'(SS_OFF_CYC - 1)) begin
          q_nxt.step = q_r.step + 3'h1;
          q_nxt.st = S_STEP;
        end
      end
      default: q_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= '0;
      q_r.st <= S_IDLE;
      q_r.wait_q <= 1'b1;
      q_r.ss_n <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign readdata = q_r.rdata;
  assign waitrequest = q_r.wait_q;
  assign link.sck = q_r.sck;
  assign link.ss_n = q_r.ss_n;
  assign link.mosi = q_r.mosi;
  assign link.mosi_oe = q_r.mosi_oe;
  assign link.tx_en = q_r.tx_en;
endmodule // coax_cfg_host
`default_nettype wire

// ---- inc/coax_cfg_pkg.sv ----
package coax_cfg_pkg;
  // Device register map
  localparam logic [6:0] REG_GENERAL = 7'h00;
  localparam logic [6:0] REG_DRIVER = 7'h01;
  localparam logic [6:0] REG_LAUNCH = 7'h02;
  localparam logic [7:0] GENERAL_RESET = 8'h08;
  localparam logic [7:0] DRIVER_RESET = 8'h64;
  localparam logic [7:0] LAUNCH_RESET = 8'h00;
  localparam logic [7:0] LAUNCH_NOMINAL = 8'h30;
  // General control fields
  localparam int CD_BIT = 0;
  localparam int MUTE_BIT = 1;
  localparam int SLEEP_LSB = 3;
  localparam int REACH_BIT = 5;
  localparam logic [1:0] SLEEP_NEVER = 2'h0;
  localparam logic [1:0] SLEEP_AUTO = 2'h1;
  localparam logic [1:0] SLEEP_FORCE = 2'h2;
  // Output driver fields
  localparam int SWING_LSB = 5;
  localparam int OFFSET_LSB = 2;
  localparam logic [2:0] OFFSET_MAX = 3'h5;
  localparam logic [2:0] SWING_TOP = 3'h4;
  localparam int SWING_BASE_MV = 400;
  localparam int SWING_STEP_MV = 100;
  localparam int CM_BASE_MV = 1050;
  localparam int CM_STEP_MV = 200;
  localparam int CM_MAX_MV = 2100;
  // Serial frame
  localparam int FRAME_BITS = 16;
  localparam int HEAD_BITS = 8;
  // Timing
  localparam int CLK_NS = 8;
  localparam int SCK_MIN_PERIOD_NS = 50;
  localparam int SS_OFF_NS = 10;
  localparam int SCK_HALF_CYC = (SCK_MIN_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int SS_OFF_CYC = (SS_OFF_NS + CLK_NS - 1) / CLK_NS;
  // Host Avalon map (byte addresses)
  localparam logic [3:0] AV_CMD = 4'h0;
  localparam logic [3:0] AV_ADDR = 4'h4;
  localparam logic [3:0] AV_WDATA = 4'h8;
  localparam logic [3:0] AV_STATUS = 4'hc;
  localparam logic [2:0] OP_RAW_WR = 3'h0;
  localparam logic [2:0] OP_RAW_RD = 3'h1;
  localparam logic [2:0] OP_RX_MODE = 3'h2;
  localparam logic [2:0] OP_TX_MODE = 3'h3;
  localparam logic [2:0] OP_TX_LOOP = 3'h4;
  localparam logic [2:0] OP_PIN_RX = 3'h5;
  localparam logic [2:0] OP_PIN_TX = 3'h6;
  localparam int CMD_NOSLEEP_BIT = 3;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_STEP = 4'h2,
    S_FRAME = 4'h4,
    S_GAP = 4'h8
  } host_state_t;

  typedef enum logic [1:0] {
    ACT_DONE = 2'h0,
    ACT_PIN = 2'h1,
    ACT_RD = 2'h2,
    ACT_WR = 2'h3
  } act_kind_t;
endpackage

// ---- inc/coax_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface coax_cfg_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic mosi_oe;
  logic miso;
  logic miso_oe;
  logic tx_en;
  logic mosi_line;
  logic miso_line;
  // Undriven lines read as high, as a pull-up would leave them
  assign mosi_line = mosi_oe ? mosi : 1'b1;
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input sck, input ss_n, input mosi_line, input tx_en,
    output miso, output miso_oe);
  modport host (output sck, output ss_n, output mosi, output mosi_oe,
    output tx_en, input miso_line);
endinterface
`default_nettype wire

// ---- rtl/coax_io_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Host drops driver enable before receive
// - Sleep field codes 01 auto, 00 never
// - Host writes 30h to launch tuning
// - Sleep code 10 forces equalizer down
// - Host raises driver enable after force-sleep
// - Active equalizer loops back transmitted data
// - Driver enable alone switches receive/transmit
// - Common mode 1.25V default, 200mV steps
// - Swing 700mV default, 100mV steps
// - Write frame: 0, addr7, data8
// - Read frame: data out from 8th fall
// - Swing code at output_driver_adjust [7:5]
// - Offset code at 01h [4:2], 101 max
module coax_io_cfg import coax_cfg_pkg::*; (
  input wire logic clk,
  input wire logic srst,
  coax_cfg_if.dev link,
  input wire logic signal_present,
  output logic eq_powered,
  output logic loopback_active,
  output logic driver_active,
  output logic outputs_muted,
  output logic ext_reach,
  output logic [9:0] swing_mv,
  output logic [11:0] output_common_mode_level_mv,
  output logic [7:0] launch_tune
);
  typedef struct packed {
    // Serial shift state
    logic sck_d;
    logic [4:0] cnt;
    logic [15:0] in_sh;
    logic [7:0] out_sh;
    logic rd;
    logic miso;
    logic miso_oe;
    // Register file
    logic [7:0] gen;
    logic [7:0] drv;
    logic [7:0] lau;
    // Registered copies of the outputs
    logic eq_on;
    logic lb;
    logic drv_on;
    logic muted;
    logic ext;
    logic [9:0] swing;
    logic [11:0] cm;
  } dev_st_t;

  dev_st_t q_r;
  dev_st_t q_nxt;

  function automatic logic [9:0] swing_to_mv(input logic [2:0] code);
    logic [2:0] c;
    c = (code > SWING_TOP) ? SWING_TOP : code;
    swing_to_mv = 10'(SWING_BASE_MV + SWING_STEP_MV * int'(c));
  endfunction

  function automatic logic [11:0] cm_to_mv(input logic [2:0] code);
    cm_to_mv = 12'(CM_MAX_MV);
    // Codes above the top step reference the outputs to the supply
    if (code < OFFSET_MAX) begin
      cm_to_mv = 12'(CM_BASE_MV + CM_STEP_MV * int'(code));
    end
  endfunction

  function automatic logic [7:0] reg_read(input logic [6:0] a,
      input dev_st_t s, input logic cd);
    reg_read = 8'h00;
    if (a == REG_GENERAL) begin
      reg_read = s.gen;
      reg_read[CD_BIT] = cd;
    end else if (a == REG_DRIVER) begin
      reg_read = s.drv;
    end else if (a == REG_LAUNCH) begin
      reg_read = s.lau;
    end
  endfunction

  // Stores a written byte; bit 0 of the general register is read-only
  function automatic dev_st_t reg_write(input dev_st_t s,
      input logic [6:0] a, input logic [7:0] d);
    reg_write = s;
    if (a == REG_GENERAL) begin
      reg_write.gen = d;
      reg_write.gen[CD_BIT] = 1'b0;
    end else if (a == REG_DRIVER) begin
      reg_write.drv = d;
    end else if (a == REG_LAUNCH) begin
      reg_write.lau = d;
    end
  endfunction

  // Forced sleep and the unused code 11 both keep the equalizer down
  function automatic logic eq_awake(input logic [1:0] code,
      input logic present);
    eq_awake = (code == SLEEP_NEVER) ||
               (code == SLEEP_AUTO && present);
  endfunction

  logic rise;
  logic fall;
  logic [15:0] shifted;
  logic head_done;
  logic frame_done;
  logic shift_out;
  // Decoded fields of the frame being shifted in
  logic head_rd;
  logic [6:0] head_addr;
  logic wr_cmd;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [1:0] sleep;
  logic eq_want;

  always_comb begin
    q_nxt = q_r;

    // Edges of the host clock, seen in the same cycle they happen
    rise = link.sck && !q_r.sck_d;
    fall = !link.sck && q_r.sck_d;
    shifted = {q_r.in_sh[14:0], link.mosi_line};
    head_done = rise && q_r.cnt == 5'(HEAD_BITS - 1);
    frame_done = rise && q_r.cnt == 5'(FRAME_BITS - 1);
    // Read data leaves on the falls between header and frame end
    shift_out = fall && q_r.rd && q_r.cnt >= 5'(HEAD_BITS) &&
                q_r.cnt < 5'(FRAME_BITS);
    head_rd = shifted[HEAD_BITS - 1];
    head_addr = shifted[6:0];
    wr_cmd = !shifted[FRAME_BITS - 1];
    wr_addr = shifted[14:8];
    wr_data = shifted[7:0];
    q_nxt.sck_d = link.sck;

    if (link.ss_n) begin
      // Frame aborted or finished: forget partial bits, release data line
      q_nxt.cnt = 5'h00;
      q_nxt.rd = 1'b0;
      q_nxt.miso_oe = 1'b0;
    end else begin
      // Rises past the sixteenth are ignored rather than wrapping
      if (rise && q_r.cnt < 5'(FRAME_BITS)) begin
        q_nxt.in_sh = shifted;
        q_nxt.cnt = q_r.cnt + 5'h01;
      end
      // Fetch on the eighth rise, half a period before data leaves
      if (head_done && head_rd) begin
        q_nxt.rd = 1'b1;
        q_nxt.out_sh = reg_read(head_addr, q_r, signal_present);
      end
      // A write commits only once all sixteen bits are in
      if (frame_done && wr_cmd) begin
        q_nxt = reg_write(q_nxt, wr_addr, wr_data);
      end
      if (shift_out) begin
        q_nxt.miso = q_r.out_sh[7];
        q_nxt.out_sh = {q_r.out_sh[6:0], 1'b0};
        q_nxt.miso_oe = 1'b1;
      end
    end

    // Status outputs follow the registers one clock later
    sleep = q_r.gen[SLEEP_LSB +: 2];
    eq_want = eq_awake(sleep, signal_present);
    q_nxt.eq_on = eq_want;
    q_nxt.drv_on = link.tx_en;
    q_nxt.lb = link.tx_en && eq_want;
    // Sleep wins over mute: a sleeping equalizer reports no mute
    q_nxt.muted = eq_want && q_r.gen[MUTE_BIT];
    q_nxt.ext = q_r.gen[REACH_BIT];
    q_nxt.swing = swing_to_mv(q_r.drv[SWING_LSB +: 3]);
    q_nxt.cm = cm_to_mv(q_r.drv[OFFSET_LSB +: 3]);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= '0;
      q_r.sck_d <= 1'b0;
      q_r.gen <= GENERAL_RESET;
      q_r.drv <= DRIVER_RESET;
      q_r.lau <= LAUNCH_RESET;
      // Derived levels start at what the reset codes decode to
      q_r.swing <= swing_to_mv(DRIVER_RESET[SWING_LSB +: 3]);
      q_r.cm <= cm_to_mv(DRIVER_RESET[OFFSET_LSB +: 3]);
    end else begin
      q_r <= q_nxt;
    end
  end

  // Every output is a register copy, never a live decode
  assign link.miso = q_r.miso;
  assign link.miso_oe = q_r.miso_oe;
  assign eq_powered = q_r.eq_on;
  assign loopback_active = q_r.lb;
  assign driver_active = q_r.drv_on;
  assign outputs_muted = q_r.muted;
  assign ext_reach = q_r.ext;
  assign swing_mv = q_r.swing;
  assign output_common_mode_level_mv = q_r.cm;
  assign launch_tune = q_r.lau;
endmodule // coax_io_cfg
`default_nettype wire

// ---- bench/coax_cfg_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module coax_cfg_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic tx_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic sck_q;
  logic [4:0] cnt_r;
  logic [4:0] seen;
  // Count includes a rise visible in this very cycle
  assign seen = cnt_r + {4'h0, sck & ~sck_q};
  always_ff @(posedge clk) begin
    sck_q <= sck;
    cnt_r <= (srst | ss_n) ? 5'h0 : seen;
  end
  sck_idle_a: assert property (ss_n |-> !sck)
    else $error("serial clock moved outside a frame");
  ss_gap_a: assert property ($rose(ss_n) |=> ss_n)
    else $error("select high for less than two cycles");
  sck_high_a: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
    else $error("serial clock high phase not four cycles");
  frame_len_a: assert property ($rose(ss_n) |-> seen == 5'h10)
    else $error("frame ended without sixteen clock rises");
  mosi_hold_a: assert property (
    sck && $past(sck) && mosi_oe |-> $stable(mosi))
    else $error("host data moved while serial clock high");
  mosi_release_a: assert property (
    $fell(mosi_oe) && !ss_n |-> seen == 5'h08)
    else $error("host data released away from eighth rise");
  miso_start_a: assert property (
    $rose(miso_oe) |-> !ss_n && !sck && !mosi_oe && seen == 5'h08)
    else $error("device data not started at eighth fall");
  no_clash_a: assert property (!(mosi_oe && miso_oe))
    else $error("both ends drive data together");
  pin_quiet_a: assert property ($changed(tx_en) |-> ss_n)
    else $error("driver enable changed inside a frame");
endmodule // coax_cfg_checker
`default_nettype wire

// ---- bench/io_direction_mode_config_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module io_direction_mode_config_bench import coax_cfg_pkg::*; ();
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic signal_present = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, eq_powered, loopback_active, driver_active;
  logic outputs_muted, ext_reach;
  logic [9:0] swing_mv;
  logic [11:0] cm_mv;
  logic [7:0] launch_tune;
  int fails = 0;
  int tests_run = 0;
  coax_cfg_if link();
  always #4 clk = ~clk;
  coax_cfg_host u_coax_cfg_host (.clk(clk), .srst(srst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .link(link));
  coax_io_cfg u_coax_io_cfg (.clk(clk), .srst(srst), .link(link),
    .signal_present(signal_present), .eq_powered(eq_powered),
    .loopback_active(loopback_active), .driver_active(driver_active),
    .outputs_muted(outputs_muted), .ext_reach(ext_reach),
    .swing_mv(swing_mv), .output_common_mode_level_mv(cm_mv),
    .launch_tune(launch_tune));
  coax_cfg_checker u_coax_cfg_checker (.clk(clk), .srst(srst),
    .sck(link.sck), .ss_n(link.ss_n), .mosi(link.mosi),
    .mosi_oe(link.mosi_oe), .miso_oe(link.miso_oe), .tx_en(link.tx_en));

  task automatic close_out;
    $display("checks %0d failures %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic op(input logic [2:0] code, input logic [6:0] ra,
    input logic [7:0] rd, input logic ns = 1'b0);
    logic [31:0] q;
    av(1'b1, AV_ADDR, {25'h0, ra}, q);
    av(1'b1, AV_WDATA, {24'h0, rd}, q);
    av(1'b1, AV_CMD, {28'h0, ns, code}, q);
    do begin
      av(1'b0, AV_STATUS, 32'h0, q);
    end while (q[0] !== 1'b0);
    // Derived outputs lag the register by a cycle
    repeat (3) @(posedge clk);
  endtask

  task automatic rd_reg(input logic [6:0] ra, output logic [7:0] v);
    logic [31:0] q;
    op(OP_RAW_RD, ra, 8'h00);
    av(1'b0, AV_STATUS, 32'h0, q);
    v = q[15:8];
  endtask

  task automatic t_reset;
    logic [31:0] q;
    av(1'b0, AV_STATUS, 32'h0, q);
    chk("status", 16'h0, q[15:0]);
    av(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 16'h0, q[15:0]);
    chk("swing", 16'h2bc, {6'h0, swing_mv});
    chk("cm", 16'h4e2, {4'h0, cm_mv});
    chk("powered", 16'h0, {15'h0, eq_powered});
  endtask

  task automatic t_codes;
    logic [15:0] e_sw;
    logic [15:0] e_cm;
    for (int c = 0; c < 8; c++) begin
      e_sw = (c > 4) ? 16'h320 : 16'(400 + 100 * c);
      e_cm = (c > 4) ? 16'h834 : 16'(1050 + 200 * c);
      op(OP_RAW_WR, REG_DRIVER, {c[2:0], c[2:0], 2'h0});
      chk("swing", e_sw, {6'h0, swing_mv});
      chk("cm", e_cm, {4'h0, cm_mv});
    end
  endtask

  task automatic t_readback;
    logic [7:0] v;
    op(OP_RAW_WR, REG_LAUNCH, 8'ha5);
    chk("tune", 16'ha5, {8'h0, launch_tune});
    rd_reg(REG_LAUNCH, v);
    chk("rd launch", 16'ha5, {8'h0, v});
    rd_reg(REG_DRIVER, v);
    chk("rd driver", 16'hfc, {8'h0, v});
    rd_reg(7'h10, v);
    chk("rd unmapped", 16'h0, {8'h0, v});
  endtask

  task automatic t_rx;
    logic [7:0] v;
    signal_present <= 1'b1;
    op(OP_RAW_WR, REG_GENERAL, 8'h22);
    chk("muted", 16'h1, {15'h0, outputs_muted});
    op(OP_RX_MODE, 7'h0, 8'h0);
    chk("tune", 16'h30, {8'h0, launch_tune});
    chk("driver", 16'h0, {15'h0, driver_active});
    chk("powered", 16'h1, {15'h0, eq_powered});
    chk("reach", 16'h1, {15'h0, ext_reach});
    rd_reg(REG_GENERAL, v);
    chk("general", 16'h2b, {8'h0, v});
  endtask

  task automatic t_tx;
    logic [7:0] v;
    logic [31:0] q;
    op(OP_TX_MODE, 7'h0, 8'h0);
    chk("powered", 16'h0, {15'h0, eq_powered});
    chk("loopback", 16'h0, {15'h0, loopback_active});
    chk("driver", 16'h1, {15'h0, driver_active});
    av(1'b0, AV_STATUS, 32'h0, q);
    chk("pin", 16'h2, {14'h0, q[1:0]});
    rd_reg(REG_GENERAL, v);
    chk("general", 16'h33, {8'h0, v});
  endtask

  task automatic t_loop;
    signal_present <= 1'b0;
    op(OP_TX_LOOP, 7'h0, 8'h0, 1'b1);
    chk("powered", 16'h1, {15'h0, eq_powered});
    chk("loopback", 16'h1, {15'h0, loopback_active});
    op(OP_PIN_RX, 7'h0, 8'h0);
    chk("driver", 16'h0, {15'h0, driver_active});
    chk("loopback", 16'h0, {15'h0, loopback_active});
    chk("powered", 16'h1, {15'h0, eq_powered});
    op(OP_PIN_TX, 7'h0, 8'h0);
    chk("loopback", 16'h1, {15'h0, loopback_active});
  endtask

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_codes();
    t_readback();
    t_rx();
    t_tx();
    t_loop();
    close_out();
  end

  // Whole run needs roughly three and a half thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule // io_direction_mode_config_bench
`default_nettype wire
